// File: rtl/hbcs_top.sv
// Host bridge command and status registers with hub-link error messaging
//
// Function
// - Fast back-to-back enable reads zero, ignores writes
// - System-error enable gates device 0 messages
// - Message mechanism enabled by either device enable
// - Address/data stepping enable reads zero, fixed
// - Parity error response enable reads zero, fixed
// - Snoop, special cycle, detected parity read zero
// - Write-invalidate enable reads zero, ignores writes
// - Bus master enable reads one, fixed
// - Memory space enable reads one, fixed
// - I/O space enable reads zero, fixed
// - Signalled system error set on sent device 0 message only
// - Received master abort flag, write one clears
// - Received target abort flag, write one clears
// - Signalled target abort reads zero, fixed
// - Select timing reads 00, fast decode
// - Master data parity error reads zero
// - Fast back-to-back capable reads one
// - Capability list present reads one
`include "hbcs_regs.svh"

module hbcs_top (
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Configuration access, already decoded to this function
   input wire logic cfg_req,
   input wire logic cfg_wr,
   input wire logic [5:0] cfg_addr,
   input wire logic [3:0] cfg_be,
   input wire logic [31:0] cfg_wdata,
   output logic [31:0] cfg_rdata,
   output logic cfg_ack,
   // Error events from the rest of the bridge
   input wire logic dev0_error_event,
   input wire logic dev1_error_event,
   input wire logic dev1_system_error_enable,
   input wire logic master_abort_rcvd,
   input wire logic target_abort_rcvd,
   // Hub link error messaging
   output logic hub_link_serr_msg,
   output logic hub_link_serr_enable
);

   localparam logic [15:0] CMD_RST = `HBCS_CMD_RST;

   hbcs_pkg::hbcs_top_st_t st_r;
   hbcs_pkg::hbcs_top_st_t st_nxt;

   logic hit;
   logic rd_hit;
   logic wr_hit;
   logic mech_en;
   logic dev0_sent;
   logic dev1_sent;
   logic [15:0] cmd_rd;
   logic [15:0] sts_rd;

   hbcs_flag_if syserr_if ();
   hbcs_flag_if mabort_if ();
   hbcs_flag_if tabort_if ();

   // Only the dword holding both registers answers with data
   assign hit = cfg_req && (cfg_addr == `HBCS_DW_CMDSTS);
   assign rd_hit = hit && !cfg_wr;
   assign wr_hit = hit && cfg_wr;

   // Either device's enable opens the shared message path
   assign mech_en = st_r.syserr_en || dev1_system_error_enable;
   assign dev0_sent = dev0_error_event && st_r.syserr_en;
   assign dev1_sent = dev1_error_event && dev1_system_error_enable;

   // Sticky status flags; clears come from byte lane 3 only
   assign syserr_if.set = dev0_sent;
   assign syserr_if.clr = wr_hit && cfg_be[3] && cfg_wdata[`HBCS_STS_LANE + `HBCS_STS_SYSERR];
   assign mabort_if.set = master_abort_rcvd;
   assign mabort_if.clr = wr_hit && cfg_be[3] && cfg_wdata[`HBCS_STS_LANE + `HBCS_STS_MABORT];
   assign tabort_if.set = target_abort_rcvd;
   assign tabort_if.clr = wr_hit && cfg_be[3] && cfg_wdata[`HBCS_STS_LANE + `HBCS_STS_TABORT];

   hbcs_flag u_syserr (
      .clock(clock),
      .resetn(resetn),
      .fl(syserr_if)
   );

   hbcs_flag u_mabort (
      .clock(clock),
      .resetn(resetn),
      .fl(mabort_if)
   );

   hbcs_flag u_tabort (
      .clock(clock),
      .resetn(resetn),
      .fl(tabort_if)
   );

   // Read images: every hardwired bit comes from the fixed pattern, so writes cannot reach it
   always_comb begin
      cmd_rd = `HBCS_CMD_FIXED;
      cmd_rd[`HBCS_CMD_SYSERR_EN] = st_r.syserr_en;
      sts_rd = `HBCS_STS_FIXED;
      sts_rd[`HBCS_STS_SYSERR] = syserr_if.q;
      sts_rd[`HBCS_STS_MABORT] = mabort_if.q;
      sts_rd[`HBCS_STS_TABORT] = tabort_if.q;
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.ack = cfg_req;
      st_nxt.msg = mech_en && (dev0_sent || dev1_sent);
      st_nxt.mech_en = mech_en;
      if (rd_hit) begin
         st_nxt.rdata = {sts_rd, cmd_rd};
      end else if (cfg_req) begin
         // Writes and unmapped dwords return zero
         st_nxt.rdata = 32'h00000000;
      end
      if (wr_hit && cfg_be[1]) begin
         st_nxt.syserr_en = cfg_wdata[`HBCS_CMD_SYSERR_EN];
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         st_r.syserr_en <= CMD_RST[`HBCS_CMD_SYSERR_EN];
         st_r.ack <= 1'b0;
         st_r.rdata <= 32'h00000000;
         st_r.msg <= 1'b0;
         st_r.mech_en <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign cfg_rdata = st_r.rdata;
   assign cfg_ack = st_r.ack;
   assign hub_link_serr_msg = st_r.msg;
   assign hub_link_serr_enable = st_r.mech_en;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);

   sequence s_read_regs;
      cfg_req && !cfg_wr && (cfg_addr == `HBCS_DW_CMDSTS);
   endsequence

   sequence s_write_cmd_hi;
      cfg_req && cfg_wr && (cfg_addr == `HBCS_DW_CMDSTS) && cfg_be[1];
   endsequence

   property p_ack;
      cfg_req |=> cfg_ack ##1 !cfg_ack || $past(cfg_req);
   endproperty
   a_ack: assert property (p_ack) else $error("Configuration access not answered");

   property p_cmd_fixed;
      s_read_regs |=> cfg_rdata[15:10] == 6'h00 && !cfg_rdata[`HBCS_CMD_FAST_BTB] && !cfg_rdata[`HBCS_CMD_STEP_EN]
         && !cfg_rdata[`HBCS_CMD_PARITY_EN] && !cfg_rdata[`HBCS_CMD_SNOOP] && !cfg_rdata[`HBCS_CMD_WRINV_EN]
         && !cfg_rdata[`HBCS_CMD_SPCYC_EN] && !cfg_rdata[`HBCS_CMD_IO_EN];
   endproperty
   a_cmd_fixed: assert property (p_cmd_fixed) else $error("Hardwired command zero bit read one");

   property p_cmd_ones;
      s_read_regs |=> cfg_rdata[`HBCS_CMD_MASTER_EN] && cfg_rdata[`HBCS_CMD_MEM_EN];
   endproperty
   a_cmd_ones: assert property (p_cmd_ones) else $error("Bus master or memory enable read zero");

   property p_sts_fixed;
      s_read_regs |=> (cfg_rdata[31:16] & 16'h8FFF) == `HBCS_STS_FIXED;
   endproperty
   a_sts_fixed: assert property (p_sts_fixed) else $error("Hardwired status bits wrong");

   property p_system_error_enable_write;
      s_write_cmd_hi ##1 s_read_regs |=> cfg_rdata[`HBCS_CMD_SYSERR_EN] == $past(cfg_wdata[`HBCS_CMD_SYSERR_EN], 2);
   endproperty
   a_system_error_enable_write: assert property (p_system_error_enable_write) else $error("System-error enable did not take write");

   property p_msg_dev0;
      dev0_error_event && st_r.syserr_en |=> hub_link_serr_msg;
   endproperty
   a_msg_dev0: assert property (p_msg_dev0) else $error("Enabled device 0 error sent no message");

   property p_msg_gate;
      !(dev0_error_event && st_r.syserr_en) && !(dev1_error_event && dev1_system_error_enable) |=> !hub_link_serr_msg;
   endproperty
   a_msg_gate: assert property (p_msg_gate) else $error("Message sent without enabled error");

   property p_mech;
      ##1 hub_link_serr_enable == $past(st_r.syserr_en || dev1_system_error_enable);
   endproperty
   a_mech: assert property (p_mech) else $error("Message path enable is not the OR of both");

   property p_sse_read;
      dev0_error_event && st_r.syserr_en ##1 s_read_regs |=> cfg_rdata[`HBCS_STS_LANE + `HBCS_STS_SYSERR];
   endproperty
   a_sse_read: assert property (p_sse_read) else $error("Signalled system error not seen");

   property p_abort_read;
      master_abort_rcvd && target_abort_rcvd ##1 s_read_regs |=>
         cfg_rdata[`HBCS_STS_LANE + `HBCS_STS_MABORT] && cfg_rdata[`HBCS_STS_LANE + `HBCS_STS_TABORT];
   endproperty
   a_abort_read: assert property (p_abort_read) else $error("Abort flags not seen after abort");

endmodule

// File: rtl/hbcs_regs.svh
// Offsets, field positions and reset values of the host bridge command and status registers
`ifndef HBCS_REGS_SVH
`define HBCS_REGS_SVH

// Configuration offsets (bytes) and the dword that holds both registers
`define HBCS_OFF_CMD 8'h04
`define HBCS_OFF_STS 8'h06
`define HBCS_DW_CMDSTS 6'h01
`define HBCS_STS_LANE 16

// Command field positions
`define HBCS_CMD_FAST_BTB 9
`define HBCS_CMD_SYSERR_EN 8
`define HBCS_CMD_STEP_EN 7
`define HBCS_CMD_PARITY_EN 6
`define HBCS_CMD_SNOOP 5
`define HBCS_CMD_WRINV_EN 4
`define HBCS_CMD_SPCYC_EN 3
`define HBCS_CMD_MASTER_EN 2
`define HBCS_CMD_MEM_EN 1
`define HBCS_CMD_IO_EN 0

// Status field positions
`define HBCS_STS_PAR_DET 15
`define HBCS_STS_SYSERR 14
`define HBCS_STS_MABORT 13
`define HBCS_STS_TABORT 12
`define HBCS_STS_TABORT_SIG 11
`define HBCS_STS_SELT_HI 10
`define HBCS_STS_SELT_LO 9
`define HBCS_STS_MPAR 8
`define HBCS_STS_FAST_BTB 7
`define HBCS_STS_CAPLIST 4

// Reset values and the hardwired read patterns
`define HBCS_CMD_RST 16'h0006
`define HBCS_STS_RST 16'h0090
`define HBCS_CMD_FIXED 16'h0006
`define HBCS_STS_FIXED 16'h0090

`endif

// File: rtl/hbcs_pkg.sv
// Types shared by the host bridge command and status register bank
package hbcs_pkg;

   typedef struct packed {
      logic q;
   } hbcs_flag_st_t;

   typedef struct packed {
      logic syserr_en;
      logic ack;
      logic [31:0] rdata;
      logic msg;
      logic mech_en;
   } hbcs_top_st_t;

endpackage

// File: rtl/hbcs_flag_if.sv
// Set, clear and value of one sticky status flag
interface hbcs_flag_if;
   logic set;
   logic clr;
   logic q;

   modport owner (
      input set,
      input clr,
      output q
   );

   modport user (
      output set,
      output clr,
      input q
   );
endinterface

// File: rtl/hbcs_flag.sv
// Sticky status flag: set by hardware, cleared by a write of one
module hbcs_flag (
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Flag carrier
   hbcs_flag_if.owner fl
);

   hbcs_pkg::hbcs_flag_st_t st_r;
   hbcs_pkg::hbcs_flag_st_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      // Set wins so an event in the clearing cycle is never lost
      if (fl.set) begin
         st_nxt.q = 1'b1;
      end else if (fl.clr) begin
         st_nxt.q = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign fl.q = st_r.q;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);

   property p_set_wins;
      fl.set |=> fl.q;
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("Flag not set after event");

   property p_sticky;
      fl.q && !fl.clr |=> fl.q;
   endproperty
   a_sticky: assert property (p_sticky) else $error("Flag dropped without a clear");

   property p_clear;
      fl.clr && !fl.set |=> !fl.q;
   endproperty
   a_clear: assert property (p_clear) else $error("Flag survived a clearing write");

endmodule

// File: sim/hbcs_hub_partner.sv
// Hub link far side: issues abort completions on command and counts error messages
module hbcs_hub_partner (
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Bench control
   input wire logic [1:0] abort_cmd,
   output int msg_count,
   // Hub link side
   input wire logic serr_msg,
   output logic master_abort_rcvd,
   output logic target_abort_rcvd
);
   timeunit 1ns;
   timeprecision 100ps;

   // Aborts come one cycle after the command, as a real completion would lag the request
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         master_abort_rcvd <= 1'b0;
         target_abort_rcvd <= 1'b0;
         msg_count <= 0;
      end else begin
         master_abort_rcvd <= abort_cmd[0];
         target_abort_rcvd <= abort_cmd[1];
         if (serr_msg === 1'b1) begin
            msg_count <= msg_count + 1;
         end
      end
   end
endmodule

// File: sim/testbench.sv
// Self-checking bench for the host bridge command and status registers
module testbench;
   timeunit 1ns;
   timeprecision 100ps;

   logic clock, resetn, cfg_req, cfg_wr, cfg_ack, e0, e1, d1en, ma, ta, msg, en;
   logic [5:0] cfg_addr;
   logic [3:0] cfg_be;
   logic [31:0] cfg_wdata, cfg_rdata, e_rd;
   logic [1:0] abort_cmd;
   logic [15:0] rnd;
   logic syserr_en, syserr, mabort, tabort;
   int errors, num_checks, msg_count, exp_msgs;

   hbcs_top hbcs_top_inst (.clock(clock), .resetn(resetn), .cfg_req(cfg_req), .cfg_wr(cfg_wr),
      .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
      .dev0_error_event(e0), .dev1_error_event(e1), .dev1_system_error_enable(d1en),
      .master_abort_rcvd(ma), .target_abort_rcvd(ta), .hub_link_serr_msg(msg), .hub_link_serr_enable(en));

   hbcs_hub_partner hbcs_hub_partner_inst (.clock(clock), .resetn(resetn), .abort_cmd(abort_cmd),
      .msg_count(msg_count), .serr_msg(msg), .master_abort_rcvd(ma), .target_abort_rcvd(ta));

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: data %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_flag(input logic got, input logic exp, input string what);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: %s is %b", $time, what, got);
      end
   endtask

   // Model advances on what the design samples at this edge, then new inputs are launched
   task automatic step(input logic rq, wr, input logic [5:0] ad, input logic [3:0] be,
                       input logic [31:0] wd, input logic [4:0] ev);
      logic [15:0] cmd, sts;
      logic hit, ack_x, msg_x, en_x;
      @(posedge clock);
      cmd = 16'h0006 | {7'h00, syserr_en, 8'h00};
      sts = 16'h0090 | {1'b0, syserr, mabort, tabort, 12'h000};
      hit = cfg_req && cfg_wr && cfg_addr == 6'h01;
      ack_x = cfg_req;
      msg_x = (e0 & syserr_en) | (e1 & d1en);
      en_x = syserr_en | d1en;
      if (cfg_req) begin
         e_rd = (!cfg_wr && cfg_addr == 6'h01) ? {sts, cmd} : 32'h00000000;
      end
      exp_msgs += msg_x;
      // Set beats a same-cycle clear
      syserr = (syserr & !(hit & cfg_be[3] & cfg_wdata[30])) | (e0 & syserr_en);
      mabort = (mabort & !(hit & cfg_be[3] & cfg_wdata[29])) | ma;
      tabort = (tabort & !(hit & cfg_be[3] & cfg_wdata[28])) | ta;
      if (hit & cfg_be[1]) begin
         syserr_en = cfg_wdata[8];
      end
      cfg_req <= rq;
      cfg_wr <= wr;
      cfg_addr <= ad;
      cfg_be <= be;
      cfg_wdata <= wd;
      {abort_cmd, d1en, e1, e0} <= ev;
      #1;
      chk_flag(cfg_ack, ack_x, "ack");
      chk_data(cfg_rdata, e_rd);
      chk_flag(msg, msg_x, "serr message");
      chk_flag(en, en_x, "serr enable");
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   initial begin
      #40000;
      errors++;
      end_sim();
   end

   initial begin
      logic [15:0] r2;
      {resetn, cfg_req, cfg_wr, cfg_addr, cfg_be, cfg_wdata, abort_cmd, d1en, e1, e0} = '0;
      {syserr_en, syserr, mabort, tabort, e_rd} = '0;
      rnd = 16'h0015;
      repeat (5) @(posedge clock);
      resetn <= 1'b1;
      step(1'b1, 1'b0, 6'h01, 4'h0, 32'h00000000, 5'h00);
      step(1'b0, 1'b0, 6'h01, 4'h0, 32'h00000000, 5'h00);
      $display("test reset values done");
      // Unmapped indices, partial lanes, W1C races and sparse events all come from the draws
      repeat (800) begin
         rnd = lfsr(rnd);
         r2 = lfsr(rnd);
         rnd = lfsr(r2);
         step(rnd[0] | rnd[1], rnd[2], {4'h0, rnd[4:3]}, r2[3:0], {rnd, r2}, r2[8:4] & rnd[9:5]);
      end
      step(1'b1, 1'b0, 6'h01, 4'h0, 32'h00000000, 5'h00);
      step(1'b0, 1'b0, 6'h01, 4'h0, 32'h00000000, 5'h00);
      repeat (2) @(posedge clock);
      chk_data(32'(msg_count), 32'(exp_msgs));
      $display("test random traffic done");
      end_sim();
   end
endmodule
